// File: design/cmc_mode_config.sv
// Mode and configuration control of a CAN controller, reached over APB.
// Assumes a protocol engine beside it that sends its bit stream and frame events here and takes
// the gated receive bit, transmit permission and counter freeze back; CAN pins are synchronous.
`timescale 1ns/10ps

module cmc_mode_config (
  input  wire logic        CLK_IN,              // Module clock, 125 MHz.
  input  wire logic        RST_B_IN,            // Asynchronous reset, active low.
  input  wire logic        PSEL_IN,             // APB select.
  input  wire logic        PENABLE_IN,          // APB enable.
  input  wire logic        PWRITE_IN,           // APB direction, high for write.
  input  wire logic [11:0] PADDR_IN,            // APB byte address.
  input  wire logic [31:0] PWDATA_IN,           // APB write data.
  output logic      [31:0] PRDATA_OUT,          // APB read data.
  output logic             PREADY_OUT,          // APB ready.
  output logic             PSLVERR_OUT,         // APB error for unmapped addresses.
  input  wire logic        RECEIVE_PIN_IN,      // CAN receive pin, low is dominant.
  output logic             TRANSMIT_PIN_OUT,    // CAN transmit pin, low is dominant.
  input  wire logic        ENG_TX_BIT_IN,       // Bit the engine wants to send.
  input  wire logic        ENG_ACK_SLOT_IN,     // Engine is in the acknowledge slot.
  input  wire logic        ENG_ERR_FRAME_IN,    // Engine is sending an error frame or acknowledge bit.
  input  wire logic        ENG_RX_BUSY_IN,      // Engine is receiving a frame.
  input  wire logic        ENG_TXBUF_EMPTY_IN,  // All transmit buffers are empty.
  input  wire logic        ENG_TX_DONE_IN,      // Pulse: engine finished sending a frame.
  input  wire logic        ENG_RX_DONE_IN,      // Pulse: engine received a frame.
  output logic             ENG_RX_BIT_OUT,      // Receive bit handed to the engine.
  output logic             TX_ALLOWED_OUT,      // Engine may start a transmission.
  output logic             CNT_FREEZE_OUT,      // Error counters must hold.
  output logic             ABORT_OUT,           // Abort traffic and drop synchronization.
  output logic             TX_EVT_OUT,          // Pulse: transmit interrupt event.
  output logic             RX_EVT_OUT,          // Pulse: receive interrupt event.
  output logic             BUSOFF_AUTO_OUT,     // High for automatic bus-off recovery.
  output logic             RECOVER_REQ_OUT,     // Pulse: software bus-off recovery request.
  output logic             CLK_SRC_SEL_OUT,     // Clock source: 0 oscillator, 1 bus clock.
  output logic             MODULE_ENABLE_OUT,   // Controller enabled.
  output logic             TQ_TICK_OUT,         // Pulse per time quantum.
  output logic      [2:0]  SJW_TQ_OUT           // Sync jump width in time quanta, 1 to 4.
);

  cmc_pkg::cmc_state_t s_q;
  cmc_pkg::cmc_state_t s_d;

  logic [7:0] idx;
  logic [2:0] sub;
  logic       setup_phase;
  logic       wr_commit;
  logic       init_active;
  logic       sleep_active;
  logic       dominant;
  logic       wake_hit;
  logic       mapped;
  logic [7:0] rd_byte;
  logic [7:0] wb;

  assign idx          = PADDR_IN[9:2];
  assign sub          = PADDR_IN[4:2];
  assign setup_phase  = PSEL_IN & !PENABLE_IN;
  // A write lands in the access cycle, when the registered ready is already high.
  assign wr_commit    = PSEL_IN & PENABLE_IN & s_q.pready & PWRITE_IN;
  assign wb           = PWDATA_IN[7:0];
  assign init_active  = s_q.init_request & s_q.ctl1.init_acknowledge;
  assign sleep_active = s_q.sleep_request & s_q.ctl1.sleep_acknowledge;
  assign dominant     = !RECEIVE_PIN_IN;

  always_comb begin
    if (s_q.ctl1.wake_filter_select) begin
      wake_hit = dominant && (s_q.wake_cnt >= cmc_pkg::WAKE_FILTER_LAST);
    end else begin
      wake_hit = dominant;
    end
  end

  // Read decode, evaluated in the setup phase so the answer is ready for the access phase.
  // The acceptance groups use a masked compare, so eight entries share one branch.
  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    if ((idx & cmc_pkg::IDX_ACC_GROUP_MASK) == cmc_pkg::IDX_ACC_CODE_BASE) begin
      rd_byte = s_q.acc_code[sub];
    end else if ((idx & cmc_pkg::IDX_ACC_GROUP_MASK) == cmc_pkg::IDX_ACC_MASK_BASE) begin
      rd_byte = s_q.acc_mask[sub];
    end else begin
      case (idx)
        cmc_pkg::IDX_CONTROL_0: begin
          rd_byte[cmc_pkg::CTL0_INIT_REQUEST_BIT]  = s_q.init_request;
          rd_byte[cmc_pkg::CTL0_SLEEP_REQUEST_BIT] = s_q.sleep_request;
          rd_byte[cmc_pkg::CTL0_WAKE_ENABLE_BIT]   = s_q.wake_enable;
        end
        cmc_pkg::IDX_CONTROL_1:    rd_byte = s_q.ctl1;
        cmc_pkg::IDX_BUS_TIMING_0: rd_byte = s_q.btr0;
        cmc_pkg::IDX_BUS_TIMING_1: rd_byte = s_q.btr1;
        cmc_pkg::IDX_ACC_CONTROL:  rd_byte = s_q.acc_control;
        cmc_pkg::IDX_STATUS: begin
          rd_byte[cmc_pkg::STAT_INIT_ACTIVE_BIT]  = init_active;
          rd_byte[cmc_pkg::STAT_SLEEP_ACTIVE_BIT] = sleep_active;
          rd_byte[cmc_pkg::STAT_TX_ALLOWED_BIT]   = s_q.tx_allowed;
          rd_byte[cmc_pkg::STAT_FREEZE_BIT]       = s_q.cnt_freeze;
          rd_byte[cmc_pkg::STAT_WAKE_COUNT_BIT]   = |s_q.wake_cnt;
        end
        default: mapped = 1'b0;
      endcase
    end
  end

  always_comb begin
    s_d = s_q;

    // APB answers with one wait-free access phase after every setup phase.
    s_d.pready = setup_phase;
    if (setup_phase) begin
      s_d.prdata  = {24'h000000, rd_byte};
      s_d.pslverr = !mapped;
    end

    s_d.recover = 1'b0;

    // Software writes. The handshake bits can be cleared only after the controller acknowledged them.
    if (wr_commit && mapped) begin
      if (idx == cmc_pkg::IDX_CONTROL_0) begin
        s_d.init_request  = wb[cmc_pkg::CTL0_INIT_REQUEST_BIT] |
                            (s_q.init_request & !s_q.ctl1.init_acknowledge);
        s_d.sleep_request = wb[cmc_pkg::CTL0_SLEEP_REQUEST_BIT] |
                            (s_q.sleep_request & !s_q.ctl1.sleep_acknowledge);
        s_d.wake_enable   = wb[cmc_pkg::CTL0_WAKE_ENABLE_BIT];
        s_d.recover       = wb[cmc_pkg::CTL0_RECOVER_BIT] & s_q.ctl1.busoff_recovery_policy;
      end
      if (init_active) begin
        if (idx == cmc_pkg::IDX_CONTROL_1) begin
          // enable written once
          // The first accepted write takes the lock whatever its value, so a stray later write
          // cannot switch the controller off.
          if (!s_q.enable_locked) begin
            s_d.ctl1.module_enable = wb[7];
            s_d.enable_locked      = 1'b1;
          end
          s_d.ctl1.clock_source_select    = wb[6];
          s_d.ctl1.self_loop_test         = wb[5];
          s_d.ctl1.monitor_only           = wb[4];
          s_d.ctl1.busoff_recovery_policy = wb[3];
          s_d.ctl1.wake_filter_select     = wb[2];
        end
        if (idx == cmc_pkg::IDX_BUS_TIMING_0) begin
          s_d.btr0 = wb;
        end
        if (idx == cmc_pkg::IDX_BUS_TIMING_1) begin
          s_d.btr1 = wb;
        end
        if (idx == cmc_pkg::IDX_ACC_CONTROL) begin
          s_d.acc_control = wb;
        end
        if ((idx & cmc_pkg::IDX_ACC_GROUP_MASK) == cmc_pkg::IDX_ACC_CODE_BASE) begin
          s_d.acc_code[sub] = wb;
        end
        if ((idx & cmc_pkg::IDX_ACC_GROUP_MASK) == cmc_pkg::IDX_ACC_MASK_BASE) begin
          s_d.acc_mask[sub] = wb;
        end
      end
    end

    s_d.ctl1.init_acknowledge = s_d.init_request;

    // enter sleep only when idle
    // Waiting for an idle bus means no frame in flight is ever cut short by sleep.
    if (!s_d.sleep_request) begin
      s_d.ctl1.sleep_acknowledge = 1'b0;
    end else if (!ENG_RX_BUSY_IN && ENG_TXBUF_EMPTY_IN) begin
      s_d.ctl1.sleep_acknowledge = 1'b1;
    end

    // Wake filter counts consecutive dominant cycles while asleep.
    // It drops back to zero at 16'hFFFF rather than saturating, so a very long dominant level restarts the count.
    if (sleep_active && dominant && s_q.wake_cnt != 16'hFFFF) begin
      s_d.wake_cnt = s_q.wake_cnt + 16'h0001;
    end else begin
      s_d.wake_cnt = 16'h0000;
    end

    if (sleep_active && s_q.wake_enable && wake_hit) begin
      s_d.ctl1.sleep_acknowledge = 1'b0;
      s_d.sleep_request          = 1'b0;
      s_d.wake_cnt               = 16'h0000;
    end

    if (s_q.ctl1.self_loop_test) begin
      s_d.rx_bit = ENG_ACK_SLOT_IN ? 1'b0 : ENG_TX_BIT_IN;
    end else begin
      s_d.rx_bit = RECEIVE_PIN_IN;
    end

    // monitor-only sends no acknowledge or error
    // init forces the pin recessive
    // The engine's acknowledge and error bits travel in the same stream, so masking the stream
    // here keeps them off the bus as well.
    s_d.tx_pin = ENG_TX_BIT_IN | !s_q.ctl1.module_enable | s_q.init_request | sleep_active |
                 s_q.ctl1.self_loop_test | s_q.ctl1.monitor_only;

    // monitor-only blocks transmit start
    // Permission drops one cycle after init is requested and acknowledged, so a new frame can still start in that one cycle.
    s_d.tx_allowed = s_q.ctl1.module_enable & !s_q.init_request & !sleep_active & !s_q.ctl1.monitor_only;

    s_d.cnt_freeze = s_q.ctl1.monitor_only;

    s_d.abort = s_q.init_request;

    s_d.tx_evt = ENG_TX_DONE_IN;
    s_d.rx_evt = ENG_RX_DONE_IN | (ENG_TX_DONE_IN & s_q.ctl1.self_loop_test);

    s_d.sjw_tq = {1'b0, s_q.btr0.sync_jump_width} + 3'h1;

    // automatic recovery flag, registered so the port comes from a flop.
    s_d.busoff_auto = !s_d.ctl1.busoff_recovery_policy;
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      // Reset is init mode with the pin recessive, so nothing reaches the bus before the
      // timing is set.
      s_q              <= '0;
      s_q.init_request <= 1'b1;
      s_q.ctl1         <= cmc_pkg::CTL1_RESET;
      s_q.tx_pin       <= 1'b1;
      s_q.rx_bit       <= 1'b1;
      s_q.abort        <= 1'b1;
      s_q.sjw_tq       <= 3'h1;
      s_q.busoff_auto  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  cmc_tq_gen u_tq_gen (
    .clk_in      (CLK_IN),
    .rst_b_in    (RST_B_IN),
    .run_in      (s_q.ctl1.module_enable & !s_q.init_request & !sleep_active),
    .prescale_in (s_q.btr0.baud_prescaler),
    .tq_tick_out (TQ_TICK_OUT)
  );

  // Every output is a register bit; only wiring stands between the state and the ports.
  assign PRDATA_OUT        = s_q.prdata;
  assign PREADY_OUT        = s_q.pready;
  assign PSLVERR_OUT       = s_q.pslverr;
  assign TRANSMIT_PIN_OUT  = s_q.tx_pin;
  assign ENG_RX_BIT_OUT    = s_q.rx_bit;
  assign TX_ALLOWED_OUT    = s_q.tx_allowed;
  assign CNT_FREEZE_OUT    = s_q.cnt_freeze;
  assign ABORT_OUT         = s_q.abort;
  assign TX_EVT_OUT        = s_q.tx_evt;
  assign RX_EVT_OUT        = s_q.rx_evt;
  assign BUSOFF_AUTO_OUT   = s_q.busoff_auto;
  assign RECOVER_REQ_OUT   = s_q.recover;
  assign CLK_SRC_SEL_OUT   = s_q.ctl1.clock_source_select;
  assign MODULE_ENABLE_OUT = s_q.ctl1.module_enable;
  assign SJW_TQ_OUT        = s_q.sjw_tq;

endmodule

// File: design/cmc_pkg.sv
// Package for the CAN mode and configuration block: register indices, field layouts and timing counts.
// Assumes a 125 MHz module clock and an APB bus with 32-bit data, one register per aligned word.
package cmc_pkg;

  // Register indices; the byte address on APB is four times the index.
  localparam logic [7:0] IDX_CONTROL_0      = 8'h00;
  localparam logic [7:0] IDX_CONTROL_1      = 8'h01;
  localparam logic [7:0] IDX_BUS_TIMING_0   = 8'h02;
  localparam logic [7:0] IDX_BUS_TIMING_1   = 8'h03;
  localparam logic [7:0] IDX_STATUS         = 8'h04;
  localparam logic [7:0] IDX_ACC_CONTROL    = 8'h0B;
  localparam logic [7:0] IDX_ACC_CODE_BASE  = 8'h10;
  localparam logic [7:0] IDX_ACC_MASK_BASE  = 8'h18;
  localparam logic [7:0] IDX_ACC_GROUP_MASK = 8'hF8;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_LSB = 2;

  // Control register 0 bit positions.
  localparam int unsigned CTL0_INIT_REQUEST_BIT  = 0;
  localparam int unsigned CTL0_SLEEP_REQUEST_BIT = 1;
  localparam int unsigned CTL0_WAKE_ENABLE_BIT   = 2;
  localparam int unsigned CTL0_RECOVER_BIT       = 3;

  // Bus timing register 0 fields.
  localparam int unsigned BTR0_SJW_LSB = 6;
  localparam int unsigned BTR0_BRP_LSB = 0;

  // Status register bit positions.
  localparam int unsigned STAT_INIT_ACTIVE_BIT  = 0;
  localparam int unsigned STAT_SLEEP_ACTIVE_BIT = 1;
  localparam int unsigned STAT_TX_ALLOWED_BIT   = 2;
  localparam int unsigned STAT_FREEZE_BIT       = 3;
  localparam int unsigned STAT_WAKE_COUNT_BIT   = 4;

  localparam logic [7:0] BTR_RESET  = 8'h00;
  localparam logic [7:0] ACC_RESET  = 8'h00;

  // Wake filter time and the clock period it is counted in; a least time rounds up.
  localparam int unsigned WAKE_FILTER_TIME_NS = 2000;
  localparam int unsigned CLK_PERIOD_NS       = 8;
  localparam int unsigned WAKE_FILTER_CYCLES  = (WAKE_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] WAKE_FILTER_LAST    = 16'(WAKE_FILTER_CYCLES - 1);

  // Control register 1 layout, bit 7 first.
  typedef struct packed {
    logic module_enable;
    logic clock_source_select;
    logic self_loop_test;
    logic monitor_only;
    logic busoff_recovery_policy;
    logic wake_filter_select;
    logic sleep_acknowledge;
    logic init_acknowledge;
  } cmc_control_1_t;

  localparam cmc_control_1_t CTL1_RESET = cmc_control_1_t'(8'h01);

  // Bus timing register 0 layout.
  typedef struct packed {
    logic [1:0] sync_jump_width;
    logic [5:0] baud_prescaler;
  } cmc_bus_timing_0_t;

  // Whole state of the main module.
  typedef struct packed {
    logic                   init_request;
    logic                   sleep_request;
    logic                   wake_enable;
    cmc_control_1_t         ctl1;
    logic                   enable_locked;
    cmc_bus_timing_0_t      btr0;
    logic [7:0]             btr1;
    logic [7:0]             acc_control;
    logic [7:0][7:0]        acc_code;
    logic [7:0][7:0]        acc_mask;
    logic [15:0]            wake_cnt;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic                   tx_pin;
    logic                   rx_bit;
    logic                   tx_allowed;
    logic                   cnt_freeze;
    logic                   abort;
    logic                   tx_evt;
    logic                   rx_evt;
    logic                   recover;
    logic [2:0]             sjw_tq;
    logic                   busoff_auto;
  } cmc_state_t;

  // State of the time-quantum generator.
  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } cmc_tq_state_t;

endpackage

// File: design/cmc_tq_gen.sv
// Time-quantum tick generator: divides the module clock by the prescaler field plus one.
// Assumes the prescale value is stable while enabled; it changes only in initialization mode.
`timescale 1ns/10ps
module cmc_tq_gen (
  input  wire logic       clk_in,        // Module clock.
  input  wire logic       rst_b_in,      // Asynchronous reset, active low.
  input  wire logic       run_in,        // High while the tick may run.
  input  wire logic [5:0] prescale_in,   // Prescaler field value.
  output logic            tq_tick_out    // One-cycle pulse per time quantum.
);

  cmc_pkg::cmc_tq_state_t s_q;
  cmc_pkg::cmc_tq_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!run_in) begin
      s_d.cnt = 6'h00;
    end else if (s_q.cnt >= prescale_in) begin
      s_d.cnt  = 6'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tq_tick_out = s_q.tick;

endmodule

// File: sim/cmc_mode_config_monitor.sv
// Checker for the CAN mode and configuration block, bound to the top module.
// Assumes one clock domain and the asynchronous active-low reset of the top module.
`timescale 1ns/10ps
module cmc_mode_config_monitor (
  input wire logic        CLK_IN,           // Module clock.
  input wire logic        RST_B_IN,         // Reset, active low.
  input wire logic        PSEL_IN,          // APB select.
  input wire logic        PENABLE_IN,       // APB enable.
  input wire logic [31:0] PRDATA_OUT,       // APB read data.
  input wire logic        PREADY_OUT,       // APB ready.
  input wire logic        TRANSMIT_PIN_OUT, // CAN transmit pin.
  input wire logic        ENG_TX_DONE_IN,   // Frame sent pulse.
  input wire logic        ENG_RX_DONE_IN,   // Frame received pulse.
  input wire logic        TX_ALLOWED_OUT,   // Transmission permitted.
  input wire logic        CNT_FREEZE_OUT,   // Error counters held.
  input wire logic        ABORT_OUT,        // Traffic abort.
  input wire logic        TX_EVT_OUT,       // Transmit event.
  input wire logic        RX_EVT_OUT,       // Receive event.
  input wire logic [2:0]  SJW_TQ_OUT        // Sync jump width in quanta.
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  a_ready_after_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  a_read_upper_zero: assert property (PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_jump_width_range: assert property (SJW_TQ_OUT inside {[3'h1:3'h4]})
    else $error("jump width out of range");
  a_tx_event_follows: assert property (ENG_TX_DONE_IN |=> TX_EVT_OUT)
    else $error("transmit event missing");
  a_rx_event_cause: assert property (RX_EVT_OUT |-> $past(ENG_RX_DONE_IN) || $past(ENG_TX_DONE_IN))
    else $error("receive event without cause");
  a_rx_event_follows: assert property (ENG_RX_DONE_IN |=> RX_EVT_OUT)
    else $error("receive event missing");
  a_abort_quiet: assert property (ABORT_OUT && $past(ABORT_OUT) |-> TRANSMIT_PIN_OUT && !TX_ALLOWED_OUT)
    else $error("traffic during abort");
  a_freeze_no_send: assert property (CNT_FREEZE_OUT && $past(CNT_FREEZE_OUT) |-> TRANSMIT_PIN_OUT && !TX_ALLOWED_OUT)
    else $error("monitor mode may transmit");
endmodule

// File: sim/cmc_mode_config_tb.sv
// Testbench for the CAN mode and configuration block: APB tasks and sequences of calls.
// Assumes one 125 MHz clock and a single-cycle APB answer from the block.
`timescale 1ns/10ps
module cmc_mode_config_tb;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, tx_pin, rx_pin, dom;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        tx_bit, ack_slot, rx_busy, txbuf_empty, tx_done, rx_done;
  logic        eng_rx_bit, tx_allowed, cnt_freeze, abort_s, tx_evt, rx_evt, busoff_auto, recover;
  logic        clk_src, mod_en, tq_tick;
  logic [2:0]  sjw_tq;
  logic [7:0]  rd;
  logic        er;
  int          err_count, n_tests, c;

  cmc_node_model cmc_node_model_inst (.tx_pin_in(tx_pin), .dominant_in(dom), .bus_out(rx_pin));
  cmc_mode_config cmc_mode_config_inst (.CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RECEIVE_PIN_IN(rx_pin), .TRANSMIT_PIN_OUT(tx_pin),
    .ENG_TX_BIT_IN(tx_bit), .ENG_ACK_SLOT_IN(ack_slot), .ENG_ERR_FRAME_IN(1'b0), .ENG_RX_BUSY_IN(rx_busy),
    .ENG_TXBUF_EMPTY_IN(txbuf_empty), .ENG_TX_DONE_IN(tx_done), .ENG_RX_DONE_IN(rx_done),
    .ENG_RX_BIT_OUT(eng_rx_bit), .TX_ALLOWED_OUT(tx_allowed), .CNT_FREEZE_OUT(cnt_freeze),
    .ABORT_OUT(abort_s), .TX_EVT_OUT(tx_evt), .RX_EVT_OUT(rx_evt), .BUSOFF_AUTO_OUT(busoff_auto),
    .RECOVER_REQ_OUT(recover), .CLK_SRC_SEL_OUT(clk_src), .MODULE_ENABLE_OUT(mod_en),
    .TQ_TICK_OUT(tq_tick), .SJW_TQ_OUT(sjw_tq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h", $time, m, got);
    end
  endtask

  // One APB transfer, entered right after a rising edge; it idles one cycle before returning.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("MISMATCH %0t no ready", $time);
      test_done();
    end
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string m);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp, m);
  endtask

  task automatic evt(input logic t, input logic r, input logic [1:0] exp);
    tx_done <= t;
    rx_done <= r;
    @(posedge clk);
    tx_done <= 1'b0;
    rx_done <= 1'b0;
    @(posedge clk);
    chk({6'h00, tx_evt, rx_evt}, {6'h00, exp}, "events");
  endtask

  task automatic wait_tick();
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (tq_tick !== 1'b1 && c < 100);
    if (c >= 100) begin
      err_count++;
      $display("MISMATCH %0t no tick", $time);
      test_done();
    end
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, dom, tx_bit, ack_slot, rx_busy, tx_done, rx_done} = '0;
    txbuf_empty = 1'b1;
    err_count = 0;
    n_tests = 0;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(8'h01, 8'h01, "control 1 reset");
    chk({7'h00, abort_s}, 8'h01, "abort in init");
    rdc(8'h02, 8'h00, "timing 0 reset");
    apb(1'b1, 8'h02, 8'hC5);
    rdc(8'h02, 8'hC5, "timing 0 write");
    chk({5'h00, sjw_tq}, 8'h04, "jump width");
    $display("reset and timing test done");
    apb(1'b1, 8'h01, 8'hA8);
    chk({5'h00, mod_en, clk_src, busoff_auto}, 8'h04, "enable, source, policy");
    apb(1'b1, 8'h00, 8'h09);
    chk({7'h00, recover}, 8'h01, "recovery pulse");
    repeat (2) @(posedge clk);
    chk({7'h00, eng_rx_bit}, 8'h00, "loop bit");
    tx_bit <= 1'b1;
    ack_slot <= 1'b1;
    repeat (2) @(posedge clk);
    chk({7'h00, eng_rx_bit}, 8'h00, "ack slot");
    ack_slot <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h00, eng_rx_bit}, 8'h01, "loop bit high");
    chk({7'h00, tx_pin}, 8'h01, "pin recessive");
    evt(1'b1, 1'b0, 2'b11);
    apb(1'b1, 8'h01, 8'h50);
    rdc(8'h01, 8'hD1, "enable kept");
    chk({6'h00, clk_src, busoff_auto}, 8'h03, "source and auto");
    apb(1'b1, 8'h00, 8'h00);
    rdc(8'h01, 8'hD0, "init left");
    chk({7'h00, abort_s}, 8'h00, "abort released");
    $display("loopback and config test done");
    tx_bit <= 1'b0;
    apb(1'b1, 8'h02, 8'h00);
    rdc(8'h02, 8'hC5, "timing locked");
    apb(1'b1, 8'h01, 8'h00);
    rdc(8'h01, 8'hD0, "control 1 locked");
    chk({5'h00, cnt_freeze, tx_allowed, tx_pin}, 8'h05, "monitor outputs");
    evt(1'b0, 1'b1, 2'b01);
    wait_tick();
    wait_tick();
    chk(c[7:0], 8'h06, "tick period");
    apb(1'b1, 8'h00, 8'h01);
    rdc(8'h01, 8'hD1, "init again");
    apb(1'b1, 8'h01, 8'h14);
    apb(1'b1, 8'h00, 8'h00);
    rdc(8'h01, 8'h94, "policy auto");
    $display("protection and tick test done");
    rx_busy <= 1'b1;
    apb(1'b1, 8'h00, 8'h06);
    rdc(8'h01, 8'h94, "sleep waits");
    rx_busy <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(8'h01, 8'h96, "sleep entered");
    dom <= 1'b1;
    @(posedge clk);
    dom <= 1'b0;
    rdc(8'h01, 8'h96, "short pulse filtered");
    dom <= 1'b1;
    repeat (260) @(posedge clk);
    dom <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(8'h01, 8'h94, "wake clears");
    rdc(8'h00, 8'h04, "request cleared");
    apb(1'b0, 8'h05, 8'h00);
    chk({7'h00, er}, 8'h01, "unmapped error");
    $display("sleep and wake test done");
    test_done();
  end
endmodule

bind cmc_mode_config cmc_mode_config_monitor cmc_mode_config_monitor_inst (.CLK_IN(CLK_IN),
  .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .TRANSMIT_PIN_OUT(TRANSMIT_PIN_OUT), .ENG_TX_DONE_IN(ENG_TX_DONE_IN),
  .ENG_RX_DONE_IN(ENG_RX_DONE_IN), .TX_ALLOWED_OUT(TX_ALLOWED_OUT), .CNT_FREEZE_OUT(CNT_FREEZE_OUT),
  .ABORT_OUT(ABORT_OUT), .TX_EVT_OUT(TX_EVT_OUT), .RX_EVT_OUT(RX_EVT_OUT), .SJW_TQ_OUT(SJW_TQ_OUT));

// File: sim/cmc_node_model.sv
// Other nodes on the shared CAN bus, seen as one wired-AND bus level.
// Assumes the bench drives the dominant request right after a clock edge.
`timescale 1ns/10ps
module cmc_node_model (
  input  wire logic tx_pin_in,   // Our transmit pin.
  input  wire logic dominant_in, // A remote node drives dominant.
  output logic      bus_out      // Resulting bus level.
);
  // Any dominant driver wins; the bus rests recessive through its termination.
  assign bus_out = tx_pin_in & ~dominant_in;
endmodule
